//--- src/pmic_status_pkg.sv
/*
  Constants shared by the status and event-gate register slice: register
  offsets, field positions, reset values and interrupt event layout.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package pmic_status_pkg;

  // ==========================================================================
  // Register indices as printed; the byte address is four times the index.
  // ==========================================================================
  localparam logic [7:0] IDX_STEPDOWN_LIVE = 8'h26; // Step-down live state.
  localparam logic [7:0] IDX_STEPUP_LIVE = 8'h27; // Step-up live state.
  localparam logic [7:0] IDX_MONITOR_STATE = 8'h28; // Monitor input state.
  localparam logic [7:0] IDX_GATE_A = 8'h29; // Miscellaneous event gate A.
  localparam logic [7:0] IDX_GATE_REGRESET = 8'h2a; // Register-reset event gate.
  localparam logic [7:0] IDX_GATE_STEPDOWN = 8'h2b; // Step-down event gate.
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h30; // Latched event flags.
  localparam logic [7:0] IDX_THERMAL_RAW = 8'h31; // Raw thermal warning.

  localparam int ADDR_W = 10; // Byte address width on the bus.

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int BIT_CONV_B_EN = 7; // Converter B enabled.
  localparam int BIT_CONV_B_PG = 6; // Converter B output valid.
  localparam int BIT_CONV_B_ILIM = 4; // Converter B at current limit.
  localparam int BIT_CONV_A_EN = 3; // Converter A enabled.
  localparam int BIT_CONV_A_PG = 2; // Converter A output valid.
  localparam int BIT_CONV_A_ILIM = 0; // Converter A at current limit.
  localparam int BIT_STEPUP_EN = 3; // Step-up enabled.
  localparam int BIT_STEPUP_PG = 2; // Step-up output valid.
  localparam int BIT_STEPUP_ILIM = 0; // Step-up at current limit.
  localparam int BIT_MON_B = 4; // Monitor B valid.
  localparam int BIT_MON_A = 2; // Monitor A valid.
  localparam int BIT_ANALOG = 0; // Analog supply valid.
  localparam int BIT_LOAD_MEAS_GATE = 7; // Load-measurement-ready gate.
  localparam int BIT_EXT_CLK_GATE = 3; // External clock detection gate.
  localparam int BIT_THERMAL_GATE = 1; // Thermal warning gate.
  localparam int BIT_REGRESET_GATE = 0; // Register-reset gate.

  // Event flag positions in the latched flag register.
  localparam int EV_LOAD_MEAS = 0; // Load measurement ready.
  localparam int EV_EXT_CLK = 1; // External clock detection.
  localparam int EV_THERMAL = 2; // Thermal warning.
  localparam int EV_REGRESET = 3; // Register reset.
  localparam int EV_CONV_A_ILIM = 4; // Converter A current limit.
  localparam int EV_CONV_B_ILIM = 5; // Converter B current limit.
  localparam int NUM_EVENTS = 6; // Number of event sources.

  // ==========================================================================
  // Writable bit masks and reset values.
  // ==========================================================================
  localparam logic [7:0] WMASK_GATE_A = 8'h8a; // Implemented bits of gate A.
  localparam logic [7:0] WMASK_GATE_REGRESET = 8'h01; // Implemented bits.
  localparam logic [7:0] WMASK_GATE_STEPDOWN = 8'hdd; // Implemented bits.
  localparam logic [7:0] RST_GATE_A = 8'h00; // Gate A reset value.
  localparam logic [7:0] RST_GATE_REGRESET = 8'h01; // Register-reset gate reset value.
  localparam logic [7:0] RST_GATE_STEPDOWN = 8'h00; // Step-down gate reset value.

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal completion.
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address.

endpackage

//--- src/pmic_status_irq.sv
/*
  Status and interrupt-gate register slice of a power-management device,
  reached over AXI4-Lite. Live status inputs are shown unlatched, gate
  registers take their power-up defaults from configuration memory, and
  latched event flags drive one level interrupt output.
  Assumes status inputs and event pulses are synchronous to CORE_CLK and that
  the configuration memory word is stable once OTP_VALID is high.
*/
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pmic_status_irq
  import pmic_status_pkg::*;
(
  input wire logic CORE_CLK, // System clock, 100 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY, // Read data ready.
  // Live analog status, already synchronous.
  input wire logic CONV_A_ENABLED, // Step-down converter A enabled.
  input wire logic CONV_B_ENABLED, // Step-down converter B enabled.
  input wire logic CONV_A_OUTPUT_VALID, // Converter A output valid.
  input wire logic CONV_B_OUTPUT_VALID, // Converter B output valid.
  input wire logic CONV_A_AT_CURRENT_LIMIT, // Converter A at current limit.
  input wire logic CONV_B_AT_CURRENT_LIMIT, // Converter B at current limit.
  input wire logic STEPUP_ENABLED, // Step-up converter enabled.
  input wire logic STEPUP_OUTPUT_VALID, // Step-up output valid.
  input wire logic STEPUP_AT_CURRENT_LIMIT, // Step-up at current limit.
  input wire logic MONITOR_A_VALID, // External monitor A valid.
  input wire logic MONITOR_B_VALID, // External monitor B valid.
  input wire logic ANALOG_SUPPLY_VALID, // Analog supply valid.
  input wire logic DIE_ABOVE_WARNING, // Die temperature above warning level.
  // Event detections, one-cycle pulses.
  input wire logic LOAD_MEAS_READY_EVENT, // Load current measurement ready.
  input wire logic EXT_CLK_EVENT, // External clock detection change.
  input wire logic REGRESET_EVENT, // Registers were reset.
  // Configuration memory defaults.
  input wire logic OTP_VALID, // Configuration memory word is loaded.
  input wire logic [7:0] OTP_GATE_A, // Default for gate A.
  input wire logic [7:0] OTP_GATE_REGRESET, // Default for register-reset gate.
  input wire logic [7:0] OTP_GATE_STEPDOWN, // Default for step-down gate.
  output logic IRQ // Level interrupt, high while an enabled flag is set.
);

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic [7:0] gate_a_q; // Miscellaneous event gate A.
  logic [7:0] gate_regreset_q; // Register-reset event gate.
  logic [7:0] gate_stepdown_q; // Step-down event gate.
  logic otp_done_q; // Defaults already taken from configuration memory.
  logic [NUM_EVENTS-1:0] flags_q; // Latched event flags.
  logic [NUM_EVENTS-1:0] flags_d; // Next value of the flags.
  logic [NUM_EVENTS-1:0] set_vec; // Events detected this cycle.
  logic [NUM_EVENTS-1:0] clr_vec; // Flags software clears this cycle.
  logic [NUM_EVENTS-1:0] gate_vec; // Gate bit of each event.
  logic thermal_q; // Previous raw thermal level.
  logic conv_a_ilim_q; // Previous converter A current-limit level.
  logic conv_b_ilim_q; // Previous converter B current-limit level.
  logic [ADDR_W-1:0] awaddr_q; // Captured write address.
  logic aw_held_q; // Write address captured.
  logic [31:0] wdata_q; // Captured write data.
  logic [3:0] wstrb_q; // Captured write strobes.
  logic w_held_q; // Write data captured.
  logic wr_go; // Both halves present, response channel free.
  logic [7:0] rd_word; // Decoded read value.
  logic rd_hit; // Read address is mapped.
  logic wr_hit; // Write address is mapped.
  logic [7:0] stepdown_live; // Assembled step-down status.
  logic [7:0] stepup_live; // Assembled step-up status.
  logic [7:0] monitor_live; // Assembled monitor status.

  // Word index of a byte address; low two bits are the byte lane.
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[9:2];
  endfunction

  // Merge a byte-lane write into an 8-bit register through its writable mask.
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] wmask);
    merge_byte = (old_v & ~wmask) | (new_v & wmask);
  endfunction

  // ==========================================================================
  // Live status assembly.
  // ==========================================================================
  // Status bits pass straight through; reserved positions stay zero.
  always_comb begin
    stepdown_live = 8'h00;
    stepdown_live[BIT_CONV_B_EN] = CONV_B_ENABLED;
    stepdown_live[BIT_CONV_A_EN] = CONV_A_ENABLED;
    stepdown_live[BIT_CONV_B_PG] = CONV_B_OUTPUT_VALID;
    stepdown_live[BIT_CONV_A_PG] = CONV_A_OUTPUT_VALID;
    stepdown_live[BIT_CONV_B_ILIM] = CONV_B_AT_CURRENT_LIMIT;
    stepdown_live[BIT_CONV_A_ILIM] = CONV_A_AT_CURRENT_LIMIT;
    stepup_live = 8'h00;
    stepup_live[BIT_STEPUP_EN] = STEPUP_ENABLED;
    stepup_live[BIT_STEPUP_PG] = STEPUP_OUTPUT_VALID;
    stepup_live[BIT_STEPUP_ILIM] = STEPUP_AT_CURRENT_LIMIT;
    monitor_live = 8'h00;
    monitor_live[BIT_MON_B] = MONITOR_B_VALID;
    monitor_live[BIT_MON_A] = MONITOR_A_VALID;
    monitor_live[BIT_ANALOG] = ANALOG_SUPPLY_VALID;
  end

  // ==========================================================================
  // Write channel.
  // ==========================================================================
  // Address and data are taken independently, each held until the pair
  // completes, so the master may present them in either order.
  assign S_AXI_AWREADY = !aw_held_q;
  assign S_AXI_WREADY = !w_held_q;
  assign wr_go = aw_held_q && w_held_q && !S_AXI_BVALID;
  assign wr_hit = (word_index(awaddr_q) == IDX_GATE_A) ||
                  (word_index(awaddr_q) == IDX_GATE_REGRESET) ||
                  (word_index(awaddr_q) == IDX_GATE_STEPDOWN) ||
                  (word_index(awaddr_q) == IDX_EVENT_FLAGS) ||
                  (word_index(awaddr_q) == IDX_STEPDOWN_LIVE) ||
                  (word_index(awaddr_q) == IDX_STEPUP_LIVE) ||
                  (word_index(awaddr_q) == IDX_MONITOR_STATE) ||
                  (word_index(awaddr_q) == IDX_THERMAL_RAW);

  // Capture the write address.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (S_AXI_AWVALID && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awaddr_q <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  // Capture the write data and strobes.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (S_AXI_WVALID && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================================
  // Event gate registers.
  // ==========================================================================
  // Reset leaves the documented constants; once the configuration memory
  // reports a valid word, its defaults are loaded once. A software write in
  // the same cycle is overridden, which only happens during start-up.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      gate_a_q <= RST_GATE_A;
      gate_regreset_q <= RST_GATE_REGRESET;
      gate_stepdown_q <= RST_GATE_STEPDOWN;
      otp_done_q <= 1'b0;
    end else if (OTP_VALID && !otp_done_q) begin
      gate_a_q <= OTP_GATE_A & WMASK_GATE_A;
      gate_regreset_q <= OTP_GATE_REGRESET & WMASK_GATE_REGRESET;
      gate_stepdown_q <= OTP_GATE_STEPDOWN & WMASK_GATE_STEPDOWN;
      otp_done_q <= 1'b1;
    end else if (wr_go && wstrb_q[0]) begin
      if (word_index(awaddr_q) == IDX_GATE_A) begin
        gate_a_q <= merge_byte(gate_a_q, wdata_q[7:0], WMASK_GATE_A);
      end
      if (word_index(awaddr_q) == IDX_GATE_REGRESET) begin
        gate_regreset_q <= merge_byte(gate_regreset_q, wdata_q[7:0],
                                      WMASK_GATE_REGRESET);
      end
      if (word_index(awaddr_q) == IDX_GATE_STEPDOWN) begin
        gate_stepdown_q <= merge_byte(gate_stepdown_q, wdata_q[7:0],
                                      WMASK_GATE_STEPDOWN);
      end
    end
  end

  // ==========================================================================
  // Latched event flags and interrupt.
  // ==========================================================================
  // Level sources raise a flag on entry into their active condition.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      thermal_q <= 1'b0;
      conv_a_ilim_q <= 1'b0;
      conv_b_ilim_q <= 1'b0;
    end else begin
      thermal_q <= DIE_ABOVE_WARNING;
      conv_a_ilim_q <= CONV_A_AT_CURRENT_LIMIT;
      conv_b_ilim_q <= CONV_B_AT_CURRENT_LIMIT;
    end
  end

  // Detection is never gated; the gate acts only on the interrupt output.
  always_comb begin
    set_vec = '0;
    set_vec[EV_LOAD_MEAS] = LOAD_MEAS_READY_EVENT;
    set_vec[EV_EXT_CLK] = EXT_CLK_EVENT;
    set_vec[EV_THERMAL] = DIE_ABOVE_WARNING && !thermal_q;
    set_vec[EV_REGRESET] = REGRESET_EVENT;
    set_vec[EV_CONV_A_ILIM] = CONV_A_AT_CURRENT_LIMIT && !conv_a_ilim_q;
    set_vec[EV_CONV_B_ILIM] = CONV_B_AT_CURRENT_LIMIT && !conv_b_ilim_q;
    gate_vec = '0;
    gate_vec[EV_LOAD_MEAS] = gate_a_q[BIT_LOAD_MEAS_GATE];
    gate_vec[EV_EXT_CLK] = gate_a_q[BIT_EXT_CLK_GATE];
    gate_vec[EV_THERMAL] = gate_a_q[BIT_THERMAL_GATE];
    gate_vec[EV_REGRESET] = gate_regreset_q[BIT_REGRESET_GATE];
    gate_vec[EV_CONV_A_ILIM] = gate_stepdown_q[BIT_CONV_A_ILIM];
    gate_vec[EV_CONV_B_ILIM] = gate_stepdown_q[BIT_CONV_B_ILIM];
    clr_vec = '0;
    if (wr_go && wstrb_q[0] && word_index(awaddr_q) == IDX_EVENT_FLAGS) begin
      clr_vec = wdata_q[NUM_EVENTS-1:0];
    end
    // A new event in the clearing cycle wins over the clear.
    flags_d = (flags_q & ~clr_vec) | set_vec;
  end

  // Flag register update.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Interrupt comes from a flop so it never glitches on the way out.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flags_d & ~gate_vec);
    end
  end

  // ==========================================================================
  // Read channel.
  // ==========================================================================
  // Status registers are decoded here only; writes to them touch nothing.
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 8'h00;
    case (word_index(S_AXI_ARADDR))
      IDX_STEPDOWN_LIVE: rd_word = stepdown_live;
      IDX_STEPUP_LIVE: rd_word = stepup_live;
      IDX_MONITOR_STATE: rd_word = monitor_live;
      IDX_GATE_A: rd_word = gate_a_q;
      IDX_GATE_REGRESET: rd_word = gate_regreset_q;
      IDX_GATE_STEPDOWN: rd_word = gate_stepdown_q;
      IDX_EVENT_FLAGS: rd_word = {{(8-NUM_EVENTS){1'b0}}, flags_q};
      IDX_THERMAL_RAW: rd_word = {7'h00, DIE_ABOVE_WARNING};
      default: rd_hit = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Read data is registered on the same edge that takes the address.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h000000, rd_word};
      S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

//--- test/pmic_status_irq_properties.sv
/*
  Checker for the status and event-gate register slice.
  Assumes it is bound to pmic_status_irq and sees only its ports.
*/
`timescale 1ns/1ns
module pmic_status_irq_check
  import pmic_status_pkg::*;
(
  input wire logic CORE_CLK, // Clock.
  input wire logic RST, // Reset.
  input wire logic S_AXI_AWVALID, // Write address valid.
  input wire logic S_AXI_AWREADY, // Write address ready.
  input wire logic S_AXI_WVALID, // Write data valid.
  input wire logic S_AXI_WREADY, // Write data ready.
  input wire logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [1:0] S_AXI_BRESP, // Write response.
  input wire logic S_AXI_ARVALID, // Read address valid.
  input wire logic S_AXI_ARREADY, // Read address ready.
  input wire logic [31:0] S_AXI_RDATA, // Read data.
  input wire logic [1:0] S_AXI_RRESP, // Read response.
  input wire logic S_AXI_RVALID, // Read valid.
  input wire logic S_AXI_RREADY, // Read ready.
  input wire logic LOAD_MEAS_READY_EVENT, // Event pulse.
  input wire logic EXT_CLK_EVENT, // Event pulse.
  input wire logic REGRESET_EVENT, // Event pulse.
  input wire logic DIE_ABOVE_WARNING, // Level source.
  input wire logic CONV_A_AT_CURRENT_LIMIT, // Level source.
  input wire logic CONV_B_AT_CURRENT_LIMIT, // Level source.
  input wire logic IRQ // Interrupt.
);
  // ==========
  // Helper logic.
  // ==========
  logic [3:0] bv_hist_q; // Recent write responses; gate writes act a cycle late.
  wire logic ev_any = LOAD_MEAS_READY_EVENT | EXT_CLK_EVENT | REGRESET_EVENT |
    DIE_ABOVE_WARNING | CONV_A_AT_CURRENT_LIMIT | CONV_B_AT_CURRENT_LIMIT; // Any cause.

  // History of the write response, so register effects can be traced to it.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bv_hist_q <= 4'h0;
    end else begin
      bv_hist_q <= {bv_hist_q[2:0], S_AXI_BVALID};
    end
  end

  // ==========
  // Assertions.
  // ==========
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  chk_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  // Both halves are captured at the first edge; the response rises at the next.
  chk_wr_latency: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |=> ##1 S_AXI_BVALID) else $error("write response late");
  chk_rd_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  chk_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while busy");
  chk_upper_zero: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0) else $error("upper read bits set");
  chk_slverr_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |->
    S_AXI_RDATA == 32'h0) else $error("error read carries data");
  chk_irq_rise: assert property (
    $rose(IRQ) |-> $past(ev_any) || (|bv_hist_q)) else $error("interrupt without cause");
  chk_irq_fall: assert property (
    $fell(IRQ) |-> S_AXI_BVALID || (|bv_hist_q)) else $error("interrupt fell unwritten");

  cov_irq_rise: cover property ($rose(IRQ));
  cov_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
  cov_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind pmic_status_irq pmic_status_irq_check chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .LOAD_MEAS_READY_EVENT(LOAD_MEAS_READY_EVENT), .EXT_CLK_EVENT(EXT_CLK_EVENT),
  .REGRESET_EVENT(REGRESET_EVENT), .DIE_ABOVE_WARNING(DIE_ABOVE_WARNING),
  .CONV_A_AT_CURRENT_LIMIT(CONV_A_AT_CURRENT_LIMIT),
  .CONV_B_AT_CURRENT_LIMIT(CONV_B_AT_CURRENT_LIMIT), .IRQ(IRQ));

//--- test/pmic_status_irq_test.sv
/*
  Self-checking bench for the status and event-gate register slice.
  Assumes a 100 MHz clock; the bench drives every input itself.
*/
`timescale 1ns/1ns
module pmic_status_irq_test
  import pmic_status_pkg::*;
;
  logic clk, rst, awv, wv, arv, bready, rready, otp_ok; // Bench drives.
  logic [9:0] awaddr, araddr; // Byte addresses.
  logic [31:0] wdata; // Write data.
  logic [12:0] live; // Live status levels.
  logic [5:0] ev; // Event sources, in flag order.
  logic [7:0] otp; // Configuration defaults.
  wire logic awr, wr, bv, arr, rv, irq; // Design outputs.
  wire logic [1:0] bresp, rresp; // Responses.
  wire logic [31:0] rdata; // Read data.
  int miscompares, tests_run; // Verdict counters.
  // Address and bit at which each live level shows.
  localparam logic [9:0] LA [13] = '{10'h098, 10'h098, 10'h098, 10'h098, 10'h098, 10'h098,
    10'h09c, 10'h09c, 10'h09c, 10'h0a0, 10'h0a0, 10'h0a0, 10'h0c4};
  localparam int LB [13] = '{3, 7, 2, 6, 0, 4, 3, 2, 0, 2, 4, 0, 0};
  localparam logic [9:0] RA [4] = '{10'h098, 10'h09c, 10'h0a0, 10'h0c4};
  // Gate register and bit of each event source.
  localparam logic [9:0] GA [6] = '{10'h0a4, 10'h0a4, 10'h0a4, 10'h0a8, 10'h0ac, 10'h0ac};
  localparam int GB [6] = '{7, 3, 1, 0, 0, 4};

  pmic_status_irq dut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .CONV_A_ENABLED(live[0]), .CONV_B_ENABLED(live[1]), .CONV_A_OUTPUT_VALID(live[2]),
    .CONV_B_OUTPUT_VALID(live[3]), .CONV_A_AT_CURRENT_LIMIT(live[4] | ev[4]),
    .CONV_B_AT_CURRENT_LIMIT(live[5] | ev[5]), .STEPUP_ENABLED(live[6]),
    .STEPUP_OUTPUT_VALID(live[7]), .STEPUP_AT_CURRENT_LIMIT(live[8]),
    .MONITOR_A_VALID(live[9]), .MONITOR_B_VALID(live[10]), .ANALOG_SUPPLY_VALID(live[11]),
    .DIE_ABOVE_WARNING(live[12] | ev[2]), .LOAD_MEAS_READY_EVENT(ev[0]),
    .EXT_CLK_EVENT(ev[1]), .REGRESET_EVENT(ev[3]), .OTP_VALID(otp_ok), .OTP_GATE_A(otp),
    .OTP_GATE_REGRESET(otp), .OTP_GATE_STEPDOWN(otp), .IRQ(irq));

  // ==========
  // Bus and compare tasks; handshakes are sampled at the settled falling edge.
  // ==========
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hit = awv & awr;
      w_hit = wv & wr;
      b_hit = bv;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awv <= 1'b0;
      if (w_hit) wv <= 1'b0;
    end while (!b_hit);
    bready <= 1'b0;
    compare("bresp", 32'h0, {30'h0, r});
  endtask

  task automatic rd_reg(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, r_hit;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hit = arv & arr;
      r_hit = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arv <= 1'b0;
    end while (!r_hit);
    rready <= 1'b0;
  endtask

  task automatic chk_reg(input string what, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    compare(what, exp, d);
    compare("rresp", 32'h0, {30'h0, r});
  endtask

  // Lets the interrupt settle for two edges, then looks at it.
  task automatic chk_irq(input string what, input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    compare(what, {31'h0, e}, {31'h0, irq});
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 6'h1 << i;
    @(posedge clk);
    ev <= 6'h0;
  endtask

  // ==========
  // Scenarios.
  // ==========
  // Reset values, then the configuration defaults once the memory is valid.
  task automatic gate_defaults;
    chk_reg("gate_a", 10'h0a4, 32'h0);
    chk_reg("gate_rr", 10'h0a8, 32'h1);
    chk_reg("gate_sd", 10'h0ac, 32'h0);
    otp_ok <= 1'b1;
    repeat (2) @(posedge clk);
    chk_reg("otp_a", 10'h0a4, {24'h0, WMASK_GATE_A});
    chk_reg("otp_rr", 10'h0a8, {24'h0, WMASK_GATE_REGRESET});
    chk_reg("otp_sd", 10'h0ac, {24'h0, WMASK_GATE_STEPDOWN});
  endtask

  // Walks one live level at a time, then all; everything stays masked.
  task automatic live_status;
    logic [31:0] e;
    for (int k = 0; k < 14; k++) begin
      live <= (k == 13) ? 13'h1fff : 13'h1 << k;
      for (int r = 0; r < 4; r++) begin
        e = 32'h0;
        for (int j = 0; j < 13; j++) if (LA[j] == RA[r] && (k == 13 || j == k)) e[LB[j]] = 1'b1;
        chk_reg("live", RA[r], e);
      end
    end
    live <= 13'h0;
    chk_reg("raw_low", 10'h0c4, 32'h0);
    for (int r = 0; r < 3; r++) wr_reg(RA[r], 32'hff);
    for (int r = 0; r < 3; r++) chk_reg("ro", RA[r], 32'h0);
    chk_irq("irq_masked", 1'b0);
    chk_reg("flags", 10'h0c0, 32'h34);
    wr_reg(10'h0c0, 32'h3f);
    chk_reg("flags_clr", 10'h0c0, 32'h0);
  endtask

  // Each source: open, clear by writing one, then gated and released.
  task automatic events;
    for (int i = 0; i < 6; i++) begin
      wr_reg(GA[i], 32'h0);
      pulse(i);
      chk_irq("irq_open", 1'b1);
      chk_reg("flag", 10'h0c0, 32'h1 << i);
      wr_reg(10'h0c0, 32'h1 << i);
      chk_irq("irq_clear", 1'b0);
      wr_reg(GA[i], 32'h1 << GB[i]);
      pulse(i);
      chk_irq("irq_gated", 1'b0);
      chk_reg("flag_gated", 10'h0c0, 32'h1 << i);
      wr_reg(GA[i], 32'h0);
      chk_irq("irq_ungated", 1'b1);
      wr_reg(10'h0c0, 32'h3f);
    end
  endtask

  // ==========
  // Verdict, clock, watchdog and main sequence.
  // ==========
  task automatic results;
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs about 500 cycles; this margin only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {rst, awv, wv, arv, bready, rready, otp_ok} = 7'h40;
    {awaddr, araddr, wdata, live, ev} = '0;
    otp = 8'hff;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    gate_defaults();
    live_status();
    events();
    rd_reg(10'h3fc, d, r);
    compare("unmapped_data", 32'h0, d);
    compare("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    results();
  end
endmodule
